// [pcx_crossbar.sv]
// Contract
// - serve peripherals in fixed priority, uart first
// - each signal but uart takes lowest free unskipped pin
// - assigned or bypassed pins count as occupied
// - uart tx on pin 4, rx pin 5
// - smbus and uart claim both their pins
// - leftover pins stay general purpose io
// - crossbar off keeps all pins as inputs
// - crossbar off disables every output driver
// - input kind 1 digital, 0 analog; reset digital
// - analog pin: no pullup, driver or receiver
// - drive kind per pin; smbus always open drain
// - pullup on open drain unless globally off
// - pullup off while pin drives low
// - event triggers on digital pins, never analog
// - digital pin transition flags an event
// - route select a bits 7:6 read zero
// - bits 5,4 route async and sync comparator
// - bit 3 sysclk out, bit 2 smbus
// - bit 1 routes spi on three or four pins
// - bit 0 routes uart to fixed pins
// - slave select pinned only in four wire mode
// - special functions but uart avoided only through bypass bits
// - select b bit7 pullups off, bit6 crossbar on
// - select b timers, counter input, pca channel count
module pcx_crossbar #(
    parameter int NPINS = 21
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic [1:0] slave_select_mode_i,
    input wire logic [pcx_pkg::NSIG-1:0] periph_out_i,
    input wire logic [pcx_pkg::NSIG-1:0] periph_oe_i,
    output logic [pcx_pkg::NSIG-1:0] periph_in_o,
    input wire logic [NPINS-1:0] gpio_out_i,
    output logic [NPINS-1:0] gpio_in_o,
    input wire logic [NPINS-1:0] pad_in_i,
    output logic [NPINS-1:0] pad_out_o,
    output logic [NPINS-1:0] pad_oe_o,
    output logic [NPINS-1:0] pad_pullup_o,
    output logic [NPINS-1:0] evt_edge_o
);

    localparam int NPORTS = (NPINS + 7) / 8;
    localparam int PW = 5;
    localparam int NS = pcx_pkg::NSIG;

    // ==========================================================
    // helpers
    function automatic logic [PW-1:0] pcx_first_free(input logic [NPINS-1:0] occ);
        logic [PW-1:0] idx;
        idx = PW'(NPINS);
        for (int p = NPINS - 1; p >= 0; p--)
        begin
            if (!occ[p])
                idx = PW'(p);
        end
        return idx;
    endfunction : pcx_first_free

    function automatic logic [NPINS-1:0] pcx_code_mask(input logic [NPINS-1:0][PW-1:0] sl,
                                                       input int code);
        logic [NPINS-1:0] m;
        m = '0;
        for (int p = 0; p < NPINS; p++)
            m[p] = (sl[p] == PW'(code));
        return m;
    endfunction : pcx_code_mask

    // ==========================================================
    // registers
    logic [7:0] route_a_reg;
    logic [7:0] route_b_reg;
    logic [NPORTS*8-1:0] bypass_reg;
    logic [NPORTS*8-1:0] inkind_reg;
    logic [NPORTS*8-1:0] drive_reg;
    logic [7:0] rd_next;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            route_a_reg <= pcx_pkg::RST_ROUTE;
            route_b_reg <= pcx_pkg::RST_ROUTE;
            bypass_reg <= {NPORTS{pcx_pkg::RST_BYPASS}};
            inkind_reg <= {NPORTS{pcx_pkg::RST_INKIND}};
            drive_reg <= {NPORTS{pcx_pkg::RST_DRIVE}};
            sfr_rdata_o <= pcx_pkg::RD_UNMAPPED;
        end
        else
        begin
            sfr_rdata_o <= rd_next;
            if (sfr_we_i && sfr_addr_i == pcx_pkg::ADDR_ROUTE_A)
                route_a_reg <= sfr_wdata_i & pcx_pkg::ROUTE_A_WMASK;
            if (sfr_we_i && sfr_addr_i == pcx_pkg::ADDR_ROUTE_B)
                route_b_reg <= sfr_wdata_i & pcx_pkg::ROUTE_B_WMASK;
            for (int k = 0; k < NPORTS; k++)
            begin
                if (sfr_we_i && sfr_addr_i == 8'(pcx_pkg::ADDR_BYPASS0 + k))
                    bypass_reg[k*8 +: 8] <= sfr_wdata_i;
                if (sfr_we_i && sfr_addr_i == 8'(pcx_pkg::ADDR_INKIND0 + k))
                    inkind_reg[k*8 +: 8] <= sfr_wdata_i;
                if (sfr_we_i && sfr_addr_i == 8'(pcx_pkg::ADDR_DRIVE0 + k))
                    drive_reg[k*8 +: 8] <= sfr_wdata_i;
            end
        end
    end

    // read mux, unmapped reads zero
    always_comb
    begin
        rd_next = pcx_pkg::RD_UNMAPPED;
        if (sfr_addr_i == pcx_pkg::ADDR_ROUTE_A)
            rd_next = route_a_reg;
        if (sfr_addr_i == pcx_pkg::ADDR_ROUTE_B)
            rd_next = route_b_reg;
        for (int k = 0; k < NPORTS; k++)
        begin
            if (sfr_addr_i == 8'(pcx_pkg::ADDR_BYPASS0 + k))
                rd_next = bypass_reg[k*8 +: 8];
            if (sfr_addr_i == 8'(pcx_pkg::ADDR_INKIND0 + k))
                rd_next = inkind_reg[k*8 +: 8];
            if (sfr_addr_i == 8'(pcx_pkg::ADDR_DRIVE0 + k))
                rd_next = drive_reg[k*8 +: 8];
        end
    end

    // ==========================================================
    // peripheral enables
    wire xbar_on = route_b_reg[pcx_pkg::RB_XBAR_ON];
    wire weak_off = route_b_reg[pcx_pkg::RB_WEAK_OFF];
    wire [1:0] pca_n = route_b_reg[pcx_pkg::RB_PCA_LSB +: 2];
    wire four_wire = |slave_select_mode_i;
    wire [NPINS-1:0] bypass_vec = bypass_reg[NPINS-1:0];
    wire [NPINS-1:0] in_kind_vec = inkind_reg[NPINS-1:0];
    wire [NPINS-1:0] drive_vec = drive_reg[NPINS-1:0];
    logic [NS-1:0] sig_en;

    always_comb
    begin
        sig_en = '0;
        sig_en[pcx_pkg::SIG_TX] = route_a_reg[pcx_pkg::RA_UART];
        sig_en[pcx_pkg::SIG_RX] = route_a_reg[pcx_pkg::RA_UART];
        sig_en[pcx_pkg::SIG_SCK] = route_a_reg[pcx_pkg::RA_SPI];
        sig_en[pcx_pkg::SIG_MISO] = route_a_reg[pcx_pkg::RA_SPI];
        sig_en[pcx_pkg::SIG_MOSI] = route_a_reg[pcx_pkg::RA_SPI];
        sig_en[pcx_pkg::SIG_NSS] = route_a_reg[pcx_pkg::RA_SPI] & four_wire;
        sig_en[pcx_pkg::SIG_SDA] = route_a_reg[pcx_pkg::RA_SMBUS];
        sig_en[pcx_pkg::SIG_SCL] = route_a_reg[pcx_pkg::RA_SMBUS];
        sig_en[pcx_pkg::SIG_CMP] = route_a_reg[pcx_pkg::RA_CMP];
        sig_en[pcx_pkg::SIG_CMPA] = route_a_reg[pcx_pkg::RA_CMPA];
        sig_en[pcx_pkg::SIG_SYSCLK] = route_a_reg[pcx_pkg::RA_SYSCLK];
        sig_en[pcx_pkg::SIG_PCA_CHANNEL0_OUT] = (pca_n != 2'h0);
        sig_en[pcx_pkg::SIG_CEX1] = (pca_n[1] == 1'b1);
        sig_en[pcx_pkg::SIG_CEX2] = (pca_n == 2'h3);
        sig_en[pcx_pkg::SIG_ECI] = route_b_reg[pcx_pkg::RB_ECI];
        sig_en[pcx_pkg::SIG_T0] = route_b_reg[pcx_pkg::RB_T0];
        sig_en[pcx_pkg::SIG_T1] = route_b_reg[pcx_pkg::RB_T1];
    end

    // ==========================================================
    // priority search, redone every clock; code 0 = gpio
    logic [NPINS-1:0][PW-1:0] sel;
    logic [NPINS-1:0] occ;
    logic [PW-1:0] pick;

    always_comb
    begin
        occ = bypass_vec;
        sel = '0;
        pick = '0;
        if (xbar_on)
        begin
            if (sig_en[pcx_pkg::SIG_TX])
            begin
                occ[pcx_pkg::PIN_UART_TX] = 1'b1;
                occ[pcx_pkg::PIN_UART_RX] = 1'b1;
                sel[pcx_pkg::PIN_UART_TX] = PW'(pcx_pkg::SIG_TX + 1);
                sel[pcx_pkg::PIN_UART_RX] = PW'(pcx_pkg::SIG_RX + 1);
            end
            for (int s = pcx_pkg::SIG_SEARCH_FIRST; s < NS; s++)
            begin
                if (sig_en[s])
                begin
                    pick = pcx_first_free(occ);
                    if (pick < PW'(NPINS))
                    begin
                        sel[pick] = PW'(s + 1);
                        occ[pick] = 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // pin cells
    logic [NPINS-1:0] out_next;
    logic [NPINS-1:0] oe_next;
    logic [NPINS-1:0] pu_next;
    logic [NPINS-1:0] gin_next;
    logic [NS-1:0] pin_in_next;

    always_comb
    begin
        out_next = '0;
        oe_next = '0;
        pu_next = '0;
        gin_next = '0;
        pin_in_next = '1;
        for (int p = 0; p < NPINS; p++)
        begin
            logic [PW-1:0] s;
            logic drv;
            logic val;
            logic od;
            logic rx;
            s = sel[p] - PW'(1);
            rx = pad_in_i[p] & in_kind_vec[p];
            od = ~drive_vec[p];
            drv = 1'b1;
            val = gpio_out_i[p];
            if (sel[p] != '0)
            begin
                drv = ~pcx_pkg::SIG_IS_INPUT[s] & periph_oe_i[s];
                val = periph_out_i[s];
                if (s == PW'(pcx_pkg::SIG_SDA) || s == PW'(pcx_pkg::SIG_SCL))
                    od = 1'b1;
                pin_in_next[s] = rx;
            end
            if (od && val)
                drv = 1'b0;
            drv = drv & xbar_on & in_kind_vec[p];
            oe_next[p] = drv;
            out_next[p] = drv & val & ~od;
            pu_next[p] = in_kind_vec[p] & od & ~weak_off & ~(drv & ~val);
            gin_next[p] = rx;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
            pad_pullup_o <= '0;
            gpio_in_o <= '0;
            evt_edge_o <= '0;
            periph_in_o <= '1;
        end
        else
        begin
            pad_out_o <= out_next;
            pad_oe_o <= oe_next;
            pad_pullup_o <= pu_next;
            gpio_in_o <= gin_next;
            evt_edge_o <= (gin_next ^ gpio_in_o) & in_kind_vec;
            periph_in_o <= pin_in_next;
        end
    end

    // ==========================================================
    // checks
    wire [NPINS-1:0] busy_vec = ~pcx_code_mask(sel, 0);
    wire [NPINS-1:0] smb_vec = pcx_code_mask(sel, pcx_pkg::SIG_SDA + 1)
                             | pcx_code_mask(sel, pcx_pkg::SIG_SCL + 1);
    wire [NPINS-1:0] nss_vec = pcx_code_mask(sel, pcx_pkg::SIG_NSS + 1);
    wire [NPINS-1:0] uart_pins = NPINS'(1) << pcx_pkg::PIN_UART_TX
                               | NPINS'(1) << pcx_pkg::PIN_UART_RX;

    a_uart_fixed_pins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        xbar_on && route_a_reg[pcx_pkg::RA_UART] |->
        sel[pcx_pkg::PIN_UART_TX] == PW'(pcx_pkg::SIG_TX + 1)
        && sel[pcx_pkg::PIN_UART_RX] == PW'(pcx_pkg::SIG_RX + 1))
        else $error("uart not on its fixed pins");

    a_off_no_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !$past(xbar_on) |-> pad_oe_o == '0)
        else $error("pin driven while crossbar off");

    a_off_all_gpio: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !xbar_on |-> busy_vec == '0)
        else $error("pin assigned while crossbar off");

    a_bypass_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (busy_vec & bypass_vec & ~uart_pins) == '0)
        else $error("bypassed pin was assigned");

    a_analog_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((pad_oe_o | pad_pullup_o | gpio_in_o) & ~$past(in_kind_vec)) == '0)
        else $error("analog pin not isolated");

    a_smbus_open_drain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(smb_vec) & pad_out_o) == '0)
        else $error("smbus pin driven high");

    a_pullup_low_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pad_pullup_o & pad_oe_o & ~pad_out_o) == '0)
        else $error("pullup on while driving low");

    a_route_a_unused: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(sfr_addr_i) == pcx_pkg::ADDR_ROUTE_A |-> sfr_rdata_o[7:6] == 2'h0)
        else $error("unused select bits read nonzero");

    a_nss_three_wire: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        slave_select_mode_i == 2'h0 |-> nss_vec == '0)
        else $error("slave select pinned in three wire mode");

    a_event_analog: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (evt_edge_o & ~$past(in_kind_vec)) == '0)
        else $error("event on analog pin");

endmodule : pcx_crossbar

// [pcx_pkg.sv]
package pcx_pkg;

    // ==========================================================
    // register addresses
    localparam logic [7:0] ADDR_ROUTE_A = 8'he1;
    localparam logic [7:0] ADDR_ROUTE_B = 8'he2;
    localparam logic [7:0] ADDR_BYPASS0 = 8'hd4;
    localparam logic [7:0] ADDR_INKIND0 = 8'hf1;
    localparam logic [7:0] ADDR_DRIVE0 = 8'ha4;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ==========================================================
    // reset values and writable masks
    localparam logic [7:0] RST_ROUTE = 8'h00;
    localparam logic [7:0] RST_BYPASS = 8'h00;
    localparam logic [7:0] RST_INKIND = 8'hff;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] ROUTE_A_WMASK = 8'h3f;
    localparam logic [7:0] ROUTE_B_WMASK = 8'hfb;

    // ==========================================================
    // field positions
    localparam int RA_UART = 0;
    localparam int RA_SPI = 1;
    localparam int RA_SMBUS = 2;
    localparam int RA_SYSCLK = 3;
    localparam int RA_CMP = 4;
    localparam int RA_CMPA = 5;
    localparam int RB_PCA_LSB = 0;
    localparam int RB_ECI = 3;
    localparam int RB_T0 = 4;
    localparam int RB_T1 = 5;
    localparam int RB_XBAR_ON = 6;
    localparam int RB_WEAK_OFF = 7;

    // ==========================================================
    // peripheral signals in priority order
    localparam int SIG_TX = 0;
    localparam int SIG_RX = 1;
    localparam int SIG_SCK = 2;
    localparam int SIG_MISO = 3;
    localparam int SIG_MOSI = 4;
    localparam int SIG_NSS = 5;
    localparam int SIG_SDA = 6;
    localparam int SIG_SCL = 7;
    localparam int SIG_CMP = 8;
    localparam int SIG_CMPA = 9;
    localparam int SIG_SYSCLK = 10;
    localparam int SIG_PCA_CHANNEL0_OUT = 11;
    localparam int SIG_CEX1 = 12;
    localparam int SIG_CEX2 = 13;
    localparam int SIG_ECI = 14;
    localparam int SIG_T0 = 15;
    localparam int SIG_T1 = 16;
    localparam int NSIG = 17;
    localparam int SIG_SEARCH_FIRST = 2;
    localparam logic [NSIG-1:0] SIG_IS_INPUT = 17'h1_c002;

    // fixed serial pins
    localparam int PIN_UART_TX = 4;
    localparam int PIN_UART_RX = 5;

endpackage : pcx_pkg

// [pcx_board_model.sv]
// ==========================================================
// board side of the pads: external drivers, pull-ups, floating lines
module pcx_board_model #(
    parameter int NPINS = 21
) (
    input wire logic clk_i,
    input wire logic [NPINS-1:0] pad_out_i,
    input wire logic [NPINS-1:0] pad_oe_i,
    input wire logic [NPINS-1:0] pad_pullup_i,
    input wire logic [NPINS-1:0] board_drv_i,
    input wire logic [NPINS-1:0] board_val_i,
    output logic [NPINS-1:0] pad_in_o
);
    logic flt_reg = 1'b0;

    // undriven line without pull-up wanders every cycle
    always_ff @(posedge clk_i)
    begin
        flt_reg <= ~flt_reg;
    end

    assign pad_in_o = (pad_oe_i & pad_out_i)
        | (~pad_oe_i & board_drv_i & board_val_i)
        | (~pad_oe_i & ~board_drv_i & (pad_pullup_i | {NPINS{flt_reg}}));
endmodule : pcx_board_model

// [pcx_crossbar_test.sv]
module pcx_crossbar_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NP = 21;
    logic clk_i, rst_n_i, sfr_we_i;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic [1:0] slave_select_mode_i;
    logic [pcx_pkg::NSIG-1:0] periph_out_i, periph_oe_i, periph_in_o;
    logic [NP-1:0] gpio_out_i, gpio_in_o, pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o;
    logic [NP-1:0] evt_edge_o, board_drv, board_val;
    int n_fail, checks_done;
    int sig_of [3] = '{pcx_pkg::SIG_SYSCLK, pcx_pkg::SIG_CMP, pcx_pkg::SIG_CMPA};

    pcx_crossbar #(.NPINS(NP)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i), .sfr_rdata_o(sfr_rdata_o),
        .slave_select_mode_i(slave_select_mode_i), .periph_out_i(periph_out_i),
        .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o), .gpio_out_i(gpio_out_i),
        .gpio_in_o(gpio_in_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .pad_pullup_o(pad_pullup_o), .evt_edge_o(evt_edge_o));

    pcx_board_model #(.NPINS(NP)) board (.clk_i(clk_i), .pad_out_i(pad_out_o),
        .pad_oe_i(pad_oe_o), .pad_pullup_i(pad_pullup_o), .board_drv_i(board_drv),
        .board_val_i(board_val), .pad_in_o(pad_in_i));

    // ==========================================================
    // tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_we_i <= 1'b1;
        @(posedge clk_i);
        sfr_we_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        sfr_addr_i <= a;
        repeat (2) @(posedge clk_i);
        #1;
        chk({24'h0, sfr_rdata_o}, {24'h0, exp});
    endtask : rd

    task settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // ==========================================================
    // clock and watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        test_done();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst_n_i = 1'b0;
        sfr_we_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        slave_select_mode_i = 2'b01;
        periph_out_i = '0;
        periph_oe_i = '1;
        gpio_out_i = '0;
        board_drv = 21'h00_0020;
        board_val = '0;
        n_fail = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(pcx_pkg::ADDR_ROUTE_A, 8'h00);
        rd(pcx_pkg::ADDR_ROUTE_B, 8'h00);
        rd(pcx_pkg::ADDR_BYPASS0, 8'h00);
        rd(pcx_pkg::ADDR_INKIND0, 8'hff);
        rd(pcx_pkg::ADDR_DRIVE0, 8'h00);
        rd(8'h10, pcx_pkg::RD_UNMAPPED);
        wr(pcx_pkg::ADDR_ROUTE_A, 8'hff);
        rd(pcx_pkg::ADDR_ROUTE_A, 8'h3f);
        wr(pcx_pkg::ADDR_ROUTE_B, 8'h3f);
        rd(pcx_pkg::ADDR_ROUTE_B, 8'h3b);
        settle();
        chk(pad_oe_o, 0);
        chk(periph_in_o, 32'h0001_ffff);
        // uart, smbus and one pca channel with pins 2 and 3 skipped
        gpio_out_i <= '1;
        wr(pcx_pkg::ADDR_ROUTE_A, 8'h05);
        wr(pcx_pkg::ADDR_BYPASS0, 8'h0c);
        wr(pcx_pkg::ADDR_ROUTE_B, 8'h41);
        settle();
        chk(pad_oe_o, 32'h0000_0053);
        chk(pad_out_o, 0);
        chk(pad_pullup_o, 32'h001f_ffac);
        chk(periph_in_o[pcx_pkg::SIG_RX], 0);
        chk(gpio_in_o[5], 0);
        board_drv <= 21'h00_00a0;
        @(posedge clk_i);
        #1;
        chk(evt_edge_o[7], 1);
        wr(pcx_pkg::ADDR_INKIND0, 8'h7e);
        settle();
        chk(pad_oe_o, 32'h0000_0052);
        chk(pad_pullup_o, 32'h001f_ff2c);
        board_drv <= 21'h00_0020;
        repeat (4)
        begin
            @(posedge clk_i);
            #1;
            chk(evt_edge_o[7], 0);
            chk(gpio_in_o[7], 0);
        end
        wr(pcx_pkg::ADDR_INKIND0, 8'hff);
        wr(pcx_pkg::ADDR_DRIVE0, 8'hff);
        periph_out_i <= '1;
        settle();
        chk(pad_oe_o, 32'h0000_00dc);
        chk(pad_out_o, 32'h0000_00dc);
        chk(pad_pullup_o, 32'h001f_ff03);
        wr(pcx_pkg::ADDR_ROUTE_B, 8'hc1);
        settle();
        chk(pad_pullup_o, 0);
        // spi in four and three wire modes
        wr(pcx_pkg::ADDR_DRIVE0, 8'h00);
        wr(pcx_pkg::ADDR_BYPASS0, 8'h00);
        periph_out_i <= '0;
        wr(pcx_pkg::ADDR_ROUTE_A, 8'h02);
        wr(pcx_pkg::ADDR_ROUTE_B, 8'h40);
        for (int m = 1; m >= 0; m--)
        begin
            slave_select_mode_i <= 2'(m);
            settle();
            chk(pad_oe_o, (m == 1) ? 32'h0000_000f : 32'h0000_0007);
        end
        // one single-pin output per select bit, then one pin per pca channel for counts 0..3
        for (int k = 3; k <= 5; k++)
        begin
            periph_oe_i <= 17'(1 << sig_of[k-3]);
            wr(pcx_pkg::ADDR_ROUTE_A, 8'(1 << k));
            settle();
            chk(pad_oe_o, 32'h0000_0001);
        end
        wr(pcx_pkg::ADDR_ROUTE_A, 8'h00);
        periph_oe_i <= 17'h0_3800;
        for (int c = 0; c < 4; c++)
        begin
            wr(pcx_pkg::ADDR_ROUTE_B, 8'(8'h40 | c));
            settle();
            chk(pad_oe_o, (32'h1 << c) - 1);
        end
        // counter input and timer inputs on pins 0..2
        board_drv <= 21'h00_0024;
        wr(pcx_pkg::ADDR_ROUTE_B, 8'h78);
        settle();
        chk(periph_in_o[16:14], 3'b011);
        // open drain port pin pulled low by its latch
        gpio_out_i <= 21'h1f_fff7;
        settle();
        chk(pad_oe_o, 32'h0000_0008);
        chk(pad_pullup_o[3], 0);
        test_done();
    end
endmodule : pcx_crossbar_test
